// ===== core/mem_map_pkg.sv
// Constants and types for the core memory address maps.
// Assumes one core clock; all users import the whole package.
package mem_map_pkg;

  // ----------------------------------------------------------------
  // Program memory
  // ----------------------------------------------------------------
  localparam int        PC_W      = 13;
  localparam int        PMEM_AW   = 11;
  localparam int        INSN_W    = 14;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] IRQ_VEC   = 13'h0004;
  localparam logic [12:0] PC_INC    = 13'h0001;

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------
  localparam int        OFFS_W         = 7;
  localparam int        DADDR_W        = 9;
  localparam int        BANK_HI_BIT    = 6;
  localparam int        BANK_LO_BIT    = 5;
  localparam int        IND_PAGE_BIT   = 7;
  localparam logic [6:0] SFR_TOP       = 7'h1F;
  localparam logic [6:0] COMMON_BASE   = 7'h70;
  localparam logic [6:0] OFF_INDIRECT  = 7'h00;
  localparam logic [6:0] OFF_STATUS    = 7'h03;
  localparam logic [6:0] OFF_FSP       = 7'h04;
  // Offsets 02h, 03h, 04h, 0Ah, 0Bh are shared by all banks
  localparam logic [31:0] MIRROR_MASK  = 32'h00000C1C;
  localparam logic [7:0] STATUS_RST    = 8'h00;
  localparam logic [7:0] FSP_RST       = 8'h00;
  localparam logic [7:0] DATA_ZERO     = 8'h00;

  // What a decoded data access reaches
  typedef enum logic [2:0] {
    K_NULL   = 3'b000,
    K_STATUS = 3'b001,
    K_FSP    = 3'b010,
    K_SFR    = 3'b011,
    K_GPR    = 3'b100
  } kind_t;

endpackage : mem_map_pkg

// ===== core/dmap_if.sv
// Carrier between the data access logic and the address decoder.
// Assumes the decoder is purely combinational.
interface dmap_if;
  import mem_map_pkg::*;

  logic [1:0] bank;
  logic [6:0] offset;
  logic [7:0] fsp;
  logic       ind_page;
  logic [8:0] phys_addr;
  kind_t      kind;

  modport decoder (input bank, offset, fsp, ind_page,
                   output phys_addr, kind);
  modport user    (output bank, offset, fsp, ind_page,
                   input phys_addr, kind);
endinterface : dmap_if

// ===== core/pc_seq.sv
// Program counter and fetch address for the program bus.
// Assumes the core gives at most one of irq/jump/step priority per cycle.
module pc_seq
  import mem_map_pkg::*;
#(
  parameter int AW = PMEM_AW
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Sequencing requests
  input  wire logic          irq_take,
  input  wire logic          pc_jump,
  input  wire logic [12:0]   jump_target,
  input  wire logic          fetch_step,
  // Program bus
  output logic [12:0]        pc_r,
  output logic [AW-1:0]      fetch_addr_r
);

  // Implemented memory cannot exceed the counter's reach
  if (AW < 1 || AW > PC_W) begin : g_chk
    $error("pc_seq: AW out of range");
  end

  logic [12:0]   pc_nxt;
  logic [AW-1:0] fetch_nxt;

  // ----------------------------------------------------------------
  // Next counter value
  // ----------------------------------------------------------------
  // Interrupt beats jump beats step
  always_comb begin
    pc_nxt = pc_r;
    if (!rst_n) begin
      pc_nxt = RESET_VEC;
    end else if (irq_take) begin
      pc_nxt = IRQ_VEC;
    end else if (pc_jump) begin
      pc_nxt = jump_target;
    end else if (fetch_step) begin
      pc_nxt = 13'(pc_r + PC_INC);
    end
    // Upper bits dropped: fetch wraps onto real words
    fetch_nxt = pc_nxt[AW-1:0];
  end

  // Registers only
  always_ff @(posedge clk) begin
    pc_r         <= pc_nxt;
    fetch_addr_r <= fetch_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reset_vec;
    $rose(rst_n) |-> pc_r == RESET_VEC && fetch_addr_r == '0;
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("fetch did not start at reset vector");

  property p_irq_vec;
    irq_take |=> pc_r == IRQ_VEC;
  endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("interrupt did not go to vector");

  property p_wrap;
    fetch_addr_r == pc_r[AW-1:0];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("fetch address not wrapped counter");

  property p_step;
    fetch_step && !irq_take && !pc_jump |=> pc_r == 13'($past(pc_r) + PC_INC);
  endproperty
  a_step: assert property (p_step)
    else $error("counter step wrong");

  c_irq: cover property (irq_take ##1 fetch_step);

endmodule : pc_seq

// ===== core/addr_decode.sv
// Data address decoder: bank, offset and pointer to a physical target.
// Assumes the user drives all decoder inputs every cycle.
module addr_decode
  import mem_map_pkg::*;
(
  // Decode request and result
  dmap_if.decoder dm
);

  logic [8:0] eff;
  logic [6:0] off_e;
  logic       is_sfr;
  logic       shared;

  // ----------------------------------------------------------------
  // Effective address and region
  // ----------------------------------------------------------------
  // Indirect target is decoded like any direct address
  always_comb begin
    if (dm.offset == OFF_INDIRECT) begin
      eff = {dm.ind_page, dm.fsp};
    end else begin
      eff = {dm.bank, dm.offset};
    end
    off_e  = eff[6:0];
    is_sfr = off_e <= SFR_TOP;
    // Shared SFRs and the common RAM tail fold onto bank 0
    shared = (is_sfr && MIRROR_MASK[off_e[4:0]])
             || off_e >= COMMON_BASE;
    dm.phys_addr = shared ? {2'b00, off_e} : eff;
    if (off_e == OFF_INDIRECT) begin
      dm.kind = K_NULL;      // Pointer aimed at itself reaches nothing
    end else if (off_e == OFF_STATUS) begin
      dm.kind = K_STATUS;
    end else if (off_e == OFF_FSP) begin
      dm.kind = K_FSP;
    end else if (is_sfr) begin
      dm.kind = K_SFR;
    end else begin
      dm.kind = K_GPR;
    end
  end

endmodule : addr_decode

// ===== core/mem_map_core.sv
// Core memory address maps: program fetch and banked data memory.
// Assumes the core issues at most one data request per cycle and
// answers external SFR reads combinationally in the cycle asked.
module mem_map_core
  import mem_map_pkg::*;
#(
  parameter int GPR_DEPTH = 512
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Program sequencing
  input  wire logic         irq_take,
  input  wire logic         pc_jump,
  input  wire logic [12:0]  jump_target,
  input  wire logic         fetch_step,
  // Program bus
  output logic [12:0]       pc_r,
  output logic [10:0]       fetch_addr_r,
  // Data request
  input  wire logic         dm_req,
  input  wire logic         dm_write,
  input  wire logic [6:0]   dm_offset,
  input  wire logic [7:0]   dm_wdata,
  // Data answer
  output logic [7:0]        dm_rdata_r,
  output logic              dm_rvalid_r,
  // External SFR port
  output logic              sfr_req_r,
  output logic              sfr_write_r,
  output logic [8:0]        sfr_addr_r,
  output logic [7:0]        sfr_wdata_r,
  input  wire logic [7:0]   sfr_rdata,
  // Core state
  output logic [7:0]        status_r,
  output logic [7:0]        fsp_r
);

  // Array holds the whole 9-bit data space
  if (GPR_DEPTH != (1 << DADDR_W)) begin : g_chk
    $error("mem_map_core: GPR_DEPTH must cover the data space");
  end

  // ----------------------------------------------------------------
  // Program side
  // ----------------------------------------------------------------
  // Own bus: runs regardless of any data access
  pc_seq #(
    .AW           (PMEM_AW)
  ) u_pc (
    .clk          (clk),
    .rst_n        (rst_n),
    .irq_take     (irq_take),
    .pc_jump      (pc_jump),
    .jump_target  (jump_target),
    .fetch_step   (fetch_step),
    .pc_r         (pc_r),
    .fetch_addr_r (fetch_addr_r)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  dmap_if dmap ();

  // Bank comes straight from the status bits
  assign dmap.bank     = {status_r[BANK_HI_BIT],
                          status_r[BANK_LO_BIT]};
  assign dmap.offset   = dm_offset;
  assign dmap.fsp      = fsp_r;
  assign dmap.ind_page = status_r[IND_PAGE_BIT];

  addr_decode u_dec (
    .dm (dmap.decoder)
  );

  // ----------------------------------------------------------------
  // Stage 1: decoded access
  // ----------------------------------------------------------------
  logic        s1_valid_r, s1_valid_nxt;
  logic        s1_write_r, s1_write_nxt;
  logic [8:0]  s1_phys_r,  s1_phys_nxt;
  kind_t       s1_kind_r,  s1_kind_nxt;
  logic [7:0]  s1_wdata_r, s1_wdata_nxt;
  logic        sfr_req_nxt;
  logic        sfr_write_nxt;

  // Capture decode; bank used is the one current at request time
  always_comb begin
    s1_valid_nxt  = rst_n && dm_req;
    s1_write_nxt  = dm_write;
    s1_phys_nxt   = dmap.phys_addr;
    s1_kind_nxt   = dmap.kind;
    s1_wdata_nxt  = dm_wdata;
    sfr_req_nxt   = s1_valid_nxt && dmap.kind == K_SFR;
    sfr_write_nxt = sfr_req_nxt && dm_write;
  end

  // Registers only
  always_ff @(posedge clk) begin
    s1_valid_r  <= s1_valid_nxt;
    s1_write_r  <= s1_write_nxt;
    s1_phys_r   <= s1_phys_nxt;
    s1_kind_r   <= s1_kind_nxt;
    s1_wdata_r  <= s1_wdata_nxt;
    sfr_req_r   <= sfr_req_nxt;
    sfr_write_r <= sfr_write_nxt;
    sfr_addr_r  <= s1_phys_nxt;
    sfr_wdata_r <= s1_wdata_nxt;
  end

  // ----------------------------------------------------------------
  // Core SFRs: status and pointer
  // ----------------------------------------------------------------
  logic [7:0] status_nxt;
  logic [7:0] fsp_nxt;
  logic       s1_wr;

  // Written one cycle after the request; a request in that same
  // cycle still decodes with the old bank, trading a hazard for speed
  always_comb begin
    s1_wr      = s1_valid_r && s1_write_r;
    status_nxt = status_r;
    fsp_nxt    = fsp_r;
    if (!rst_n) begin
      status_nxt = STATUS_RST;
      fsp_nxt    = FSP_RST;
    end else if (s1_wr && s1_kind_r == K_STATUS) begin
      status_nxt = s1_wdata_r;
    end else if (s1_wr && s1_kind_r == K_FSP) begin
      fsp_nxt = s1_wdata_r;
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    status_r <= status_nxt;
    fsp_r    <= fsp_nxt;
  end

  // ----------------------------------------------------------------
  // General purpose static RAM
  // ----------------------------------------------------------------
  // Full-space array; SFR slots never written, left to synthesis
  logic [7:0] gpr_mem [GPR_DEPTH];
  logic       gpr_we;

  assign gpr_we = s1_wr && s1_kind_r == K_GPR;

  // RAM has no reset, like a real SRAM macro
  always_ff @(posedge clk) begin
    if (gpr_we) begin
      gpr_mem[s1_phys_r] <= s1_wdata_r;
    end
  end

  // ----------------------------------------------------------------
  // Stage 2: read answer
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;
  logic       rvalid_nxt;

  // Reads return two edges after the request
  always_comb begin
    rvalid_nxt = rst_n && s1_valid_r && !s1_write_r;
    rdata_nxt  = dm_rdata_r;
    if (!rst_n) begin
      rdata_nxt = DATA_ZERO;
    end else if (rvalid_nxt) begin
      case (s1_kind_r)
        K_STATUS: rdata_nxt = status_r;
        K_FSP:    rdata_nxt = fsp_r;
        K_SFR:    rdata_nxt = sfr_rdata;
        K_GPR:    rdata_nxt = gpr_mem[s1_phys_r];
        default:  rdata_nxt = DATA_ZERO;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    dm_rdata_r  <= rdata_nxt;
    dm_rvalid_r <= rvalid_nxt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bank_map;
    dm_req && dm_offset > SFR_TOP && dm_offset < COMMON_BASE
      |-> dmap.phys_addr == {status_r[BANK_HI_BIT],
                             status_r[BANK_LO_BIT], dm_offset};
  endproperty
  a_bank_map: assert property (p_bank_map)
    else $error("banked address not formed from status bits");

  property p_sfr_low;
    dm_req && dm_offset != OFF_INDIRECT && dm_offset <= SFR_TOP
      |=> s1_kind_r inside {K_SFR, K_STATUS, K_FSP};
  endproperty
  a_sfr_low: assert property (p_sfr_low)
    else $error("low offset not decoded as SFR");

  property p_gpr_high;
    dm_req && dm_offset > SFR_TOP |=> s1_kind_r == K_GPR;
  endproperty
  a_gpr_high: assert property (p_gpr_high)
    else $error("high offset not decoded as RAM");

  property p_mirror;
    dm_req && dm_offset <= SFR_TOP && MIRROR_MASK[dm_offset[4:0]]
      |-> dmap.phys_addr == {2'b00, dm_offset};
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("shared SFR not folded to one register");

  property p_indirect;
    dm_req && dm_offset == OFF_INDIRECT && fsp_r[6:0] > SFR_TOP
      && fsp_r[6:0] < COMMON_BASE
      |-> dmap.phys_addr == {status_r[IND_PAGE_BIT], fsp_r};
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect address not taken from pointer");

  property p_read_latency;
    dm_req && !dm_write |-> ##2 dm_rvalid_r;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not two cycles after request");

  property p_status_write;
    s1_valid_r && s1_write_r && s1_kind_r == K_STATUS
      |=> status_r == $past(s1_wdata_r);
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("status write did not update bank bits");

  property p_sfr_strobe;
    dm_req && dmap.kind == K_SFR |=> sfr_req_r
      && sfr_addr_r == $past(dmap.phys_addr);
  endproperty
  a_sfr_strobe: assert property (p_sfr_strobe)
    else $error("SFR strobe missing or wrong address");

  property p_fsp_write;
    s1_valid_r && s1_write_r && s1_kind_r == K_FSP
      |=> fsp_r == $past(s1_wdata_r);
  endproperty
  a_fsp_write: assert property (p_fsp_write)
    else $error("pointer write did not land");

  property p_status_read;
    s1_valid_r && !s1_write_r && s1_kind_r == K_STATUS
      |=> dm_rdata_r == $past(status_r);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read returned wrong value");

  // Pointer at itself must read zero, never stale answer data
  property p_null_read;
    s1_valid_r && !s1_write_r && s1_kind_r == K_NULL
      |=> dm_rdata_r == DATA_ZERO;
  endproperty
  a_null_read: assert property (p_null_read)
    else $error("self pointer read not zero");

  property p_offset_kept;
    dm_req && dm_offset != OFF_INDIRECT
      |-> dmap.phys_addr[OFFS_W-1:0] == dm_offset;
  endproperty
  a_offset_kept: assert property (p_offset_kept)
    else $error("bank offset lost in physical address");

  property p_common_ram;
    dm_req && dm_offset >= COMMON_BASE
      |-> dmap.phys_addr == {2'b00, dm_offset};
  endproperty
  a_common_ram: assert property (p_common_ram)
    else $error("common RAM not folded to one cell");

  property p_sfr_wdata;
    dm_req && dm_write && dmap.kind == K_SFR
      |=> sfr_write_r && sfr_wdata_r == $past(dm_wdata);
  endproperty
  a_sfr_wdata: assert property (p_sfr_wdata)
    else $error("SFR write strobe or data wrong");

  property p_internal_quiet;
    dm_req && dmap.kind != K_SFR |=> !sfr_req_r;
  endproperty
  a_internal_quiet: assert property (p_internal_quiet)
    else $error("internal access leaked to SFR port");

  property p_rvalid_source;
    dm_rvalid_r |-> $past(s1_valid_r) && !$past(s1_write_r);
  endproperty
  a_rvalid_source: assert property (p_rvalid_source)
    else $error("read answer without a read request");

  c_concurrent: cover property (fetch_step && dm_req);
  c_bank3: cover property (dm_req && dmap.bank == 2'b11
                           && dm_offset > SFR_TOP);
  c_indirect: cover property (dm_req && dm_offset == OFF_INDIRECT
                              ##2 dm_rvalid_r);

endmodule : mem_map_core

// ===== sim/test_mem_map_core.sv
// Self-checking bench for the core memory address maps.
// Assumes the design carries its own assertions; the bench answers
// external SFR reads combinationally and drives inputs at falling edges.
module test_mem_map_core
  import mem_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic        irq_take;
  logic        pc_jump;
  logic [12:0] jump_target;
  logic        fetch_step;
  logic [12:0] pc_r;
  logic [10:0] fetch_addr_r;
  logic        dm_req;
  logic        dm_write;
  logic [6:0]  dm_offset;
  logic [7:0]  dm_wdata;
  logic [7:0]  dm_rdata_r;
  logic        dm_rvalid_r;
  logic        sfr_req_r;
  logic        sfr_write_r;
  logic [8:0]  sfr_addr_r;
  logic [7:0]  sfr_wdata_r;
  logic [7:0]  sfr_rdata;
  logic [7:0]  status_r;
  logic [7:0]  fsp_r;
  logic        got_sreq;
  logic        got_swr;
  logic [8:0]  got_saddr;
  logic [7:0]  got_swd;
  logic        got_rv;
  logic [7:0]  got_rd;
  int          n_errors;
  int          n_compared;

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  // Peripheral reply; off-strobe value differs so stale data shows
  assign sfr_rdata = sfr_req_r ? (sfr_addr_r[7:0] ^ 8'h5A)
                               : (sfr_addr_r[7:0] ^ 8'hA5);

  mem_map_core mem_map_core_inst (
    .clk(clk), .rst_n(rst_n), .irq_take(irq_take), .pc_jump(pc_jump),
    .jump_target(jump_target), .fetch_step(fetch_step), .pc_r(pc_r),
    .fetch_addr_r(fetch_addr_r), .dm_req(dm_req), .dm_write(dm_write),
    .dm_offset(dm_offset), .dm_wdata(dm_wdata), .dm_rdata_r(dm_rdata_r),
    .dm_rvalid_r(dm_rvalid_r), .sfr_req_r(sfr_req_r),
    .sfr_write_r(sfr_write_r), .sfr_addr_r(sfr_addr_r),
    .sfr_wdata_r(sfr_wdata_r), .sfr_rdata(sfr_rdata),
    .status_r(status_r), .fsp_r(fsp_r)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare with case inequality so an unknown never matches
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h",
               $time, what, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // One data access; strobe seen one edge on, read answer two edges on
  task automatic acc(input logic wr, input logic [6:0] off,
                     input logic [7:0] wd, input logic st);
    dm_req     = 1'b1;
    dm_write   = wr;
    dm_offset  = off;
    dm_wdata   = wd;
    fetch_step = st;
    @(negedge clk);
    dm_req     = 1'b0;
    dm_write   = 1'b0;
    fetch_step = 1'b0;
    got_sreq   = sfr_req_r;
    got_swr    = sfr_write_r;
    got_saddr  = sfr_addr_r;
    got_swd    = sfr_wdata_r;
    @(negedge clk);
    got_rv     = dm_rvalid_r;
    got_rd     = dm_rdata_r;
  endtask : acc

  // Single-cycle sequencing request; an idle edge follows so that
  // back-to-back calls never set and clear a strobe in one step
  task automatic seq(input logic irq, input logic jmp,
                     input logic [12:0] tgt, input logic st);
    irq_take    = irq;
    pc_jump     = jmp;
    jump_target = tgt;
    fetch_step  = st;
    @(negedge clk);
    irq_take    = 1'b0;
    pc_jump     = 1'b0;
    fetch_step  = 1'b0;
    @(negedge clk);
  endtask : seq

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({3'h0, pc_r}, 16'h0000, "reset pc");
    chk({5'h00, fetch_addr_r}, 16'h0000, "reset fetch");
    chk({8'h00, status_r}, 16'h0000, "reset status");
    chk({8'h00, fsp_r}, 16'h0000, "reset pointer");
    chk({14'h0, dm_rvalid_r, sfr_req_r}, 16'h0000, "reset strobes");
    $display("test reset done");
  endtask : t_reset

  // Top of 2K wraps the fetch address; top of 8K wraps the counter
  task automatic t_pc;
    seq(1'b0, 1'b0, 13'h0000, 1'b1);
    chk({3'h0, pc_r}, 16'h0001, "step pc");
    seq(1'b0, 1'b1, 13'h07FF, 1'b1);
    seq(1'b0, 1'b0, 13'h0000, 1'b1);
    chk({3'h0, pc_r}, 16'h0800, "pc past 2K");
    chk({5'h00, fetch_addr_r}, 16'h0000, "fetch wrap");
    seq(1'b0, 1'b1, 13'h1FFF, 1'b0);
    chk({5'h00, fetch_addr_r}, 16'h07FF, "fetch high");
    seq(1'b0, 1'b0, 13'h0000, 1'b1);
    chk({3'h0, pc_r}, 16'h0000, "pc 13-bit wrap");
    $display("test program counter done");
  endtask : t_pc

  // Interrupt wins over a jump and a step in the same cycle
  task automatic t_irq;
    seq(1'b1, 1'b1, 13'h0123, 1'b1);
    chk({3'h0, pc_r}, 16'h0004, "irq vector");
    chk({5'h00, fetch_addr_r}, 16'h0004, "irq fetch");
    seq(1'b0, 1'b0, 13'h0000, 1'b1);
    chk({3'h0, pc_r}, 16'h0005, "after vector");
    $display("test interrupt done");
  endtask : t_irq

  // Every bank: status select, SFR address, mirror and RAM storage
  task automatic t_banks;
    logic [1:0] b;
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      acc(1'b1, OFF_STATUS, {1'b0, b, 5'h00}, 1'b0);
      chk({8'h00, status_r}, {8'h00, 1'b0, b, 5'h00}, "status");
      chk({15'h0, got_sreq}, 16'h0000, "status internal");
      acc(1'b1, 7'h05, 8'hC0 + 8'(i), 1'b0);
      chk({6'h00, got_sreq, got_swr, 8'h00}, 16'h0300, "sfr strobe");
      chk({7'h00, got_saddr}, {7'h00, b, 7'h05}, "sfr addr");
      chk({8'h00, got_swd}, {8'h00, 8'hC0 + 8'(i)}, "sfr data");
      acc(1'b1, 7'h0A, 8'h33, 1'b0);
      chk({7'h00, got_saddr}, 16'h000A, "mirrored sfr");
      acc(1'b1, 7'h20, 8'h10 + 8'(i), 1'b0);
      chk({15'h0, got_sreq}, 16'h0000, "ram not sfr");
      acc(1'b1, 7'h6F, 8'h80 + 8'(i), 1'b0);
    end
    acc(1'b1, 7'h7F, 8'hE7, 1'b0);
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      acc(1'b1, OFF_STATUS, {1'b0, b, 5'h00}, 1'b0);
      acc(1'b0, 7'h20, 8'h00, 1'b0);
      chk({7'h00, got_rv, got_rd}, {8'h01, 8'h10 + 8'(i)}, "ram");
      acc(1'b0, 7'h6F, 8'h00, 1'b0);
      chk({7'h00, got_rv, got_rd}, {8'h01, 8'h80 + 8'(i)}, "top");
      acc(1'b0, 7'h7F, 8'h00, 1'b0);
      chk({8'h00, got_rd}, 16'h00E7, "common ram");
      acc(1'b0, 7'h05, 8'h00, 1'b0);
      chk({8'h00, got_rd}, {8'h00, b[0], 7'h05 ^ 7'h5A}, "sfr rd");
    end
    $display("test banks done");
  endtask : t_banks

  // Pointer access reaches the same cell as a direct offset
  task automatic t_indirect;
    acc(1'b1, OFF_STATUS, 8'h00, 1'b0);
    acc(1'b1, OFF_FSP, 8'h25, 1'b0);
    chk({8'h00, fsp_r}, 16'h0025, "pointer");
    acc(1'b1, OFF_INDIRECT, 8'hA5, 1'b0);
    acc(1'b0, 7'h25, 8'h00, 1'b0);
    chk({7'h00, got_rv, got_rd}, 16'h01A5, "indirect");
    acc(1'b1, 7'h26, 8'h5C, 1'b0);
    acc(1'b1, OFF_FSP, 8'h26, 1'b0);
    acc(1'b0, OFF_INDIRECT, 8'h00, 1'b0);
    chk({8'h00, got_rd}, 16'h005C, "indirect read");
    // Page bit of status lifts the pointer into banks 2 and 3
    acc(1'b1, OFF_STATUS, 8'h80, 1'b0);
    acc(1'b0, OFF_STATUS, 8'h00, 1'b0);
    chk({7'h00, got_rv, got_rd}, 16'h0180, "status read");
    acc(1'b1, OFF_FSP, 8'h25, 1'b0);
    acc(1'b1, OFF_INDIRECT, 8'h3C, 1'b0);
    acc(1'b1, OFF_STATUS, 8'h40, 1'b0);
    acc(1'b0, 7'h25, 8'h00, 1'b0);
    chk({8'h00, got_rd}, 16'h003C, "indirect page");
    // Pointer aimed at offset 00h reaches nothing and reads zero
    acc(1'b1, OFF_FSP, 8'h00, 1'b0);
    acc(1'b0, OFF_INDIRECT, 8'h00, 1'b0);
    chk({7'h00, got_rv, got_rd}, 16'h0100, "self pointer");
    acc(1'b1, OFF_STATUS, 8'h00, 1'b0);
    $display("test indirect done");
  endtask : t_indirect

  // Fetch advance and data read in the same cycle
  task automatic t_concurrent;
    logic [12:0] pc0;
    pc0 = pc_r;
    acc(1'b0, 7'h25, 8'h00, 1'b1);
    chk({3'h0, pc_r}, {3'h0, pc0 + 13'h0001}, "pc step");
    chk({7'h00, got_rv, got_rd}, 16'h01A5, "data read");
    $display("test concurrent done");
  endtask : t_concurrent

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk         = 1'b0;
    rst_n       = 1'b0;
    irq_take    = 1'b0;
    pc_jump     = 1'b0;
    jump_target = 13'h0000;
    fetch_step  = 1'b0;
    dm_req      = 1'b0;
    dm_write    = 1'b0;
    dm_offset   = 7'h00;
    dm_wdata    = 8'h00;
    n_errors    = 0;
    n_compared  = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_pc();
    t_irq();
    t_banks();
    t_indirect();
    t_concurrent();
    final_report();
  end

  // Well above the roughly 150 cycles the scenarios need
  initial begin
    #(25 * 5000);
    n_errors++;
    final_report();
  end
endmodule : test_mem_map_core
